// >>> pmp_defs.svh
// constants for the program message parser
//
// Notes on behaviour
// - path starts at root, colon descends
// - semicolon splits message into commands
// - colon after semicolon resets to root
// - bare word after semicolon keeps level
// - non-root word after root reset errors
// - leading colon optional, same meaning
// - optional root skipped, next level accepted
// - path pointer only moves down
// - common commands keep path pointer
// - line feed or eoi ends message
// - commands execute in message order
// - invalid command errors, not executed
// - commands after an error are discarded
// - responses queued, sent when talk addressed
// - semicolons between responses
// - response ends line feed with eoi
// - clear status zeroes events and errors
// - opc sets bit when work finished
// - opc query queues ascii one
// - event status query reads and clears
// - command words are case insensitive
// - short forms accepted per vowel rule
// - command error sets event bit five
`ifndef PMP_DEFS_SVH
`define PMP_DEFS_SVH
// ==========================================
// characters
`define PMP_CH_LF      8'h0A
`define PMP_CH_SEMI    8'h3B
`define PMP_CH_COLON   8'h3A
`define PMP_CH_STAR    8'h2A
`define PMP_CH_QUERY   8'h3F
`define PMP_CH_SPACE   8'h20
`define PMP_CH_ONE     8'h31
`define PMP_CH_ZERO    8'h30
`define PMP_CH_SEP     8'h3B
`define PMP_CASE_BIT   8'h20
// ==========================================
// event register fields and sizes
`define PMP_ESR_OPC    0
`define PMP_ESR_QYE    2
`define PMP_ESR_CMD_ERR 5
`define PMP_ESR_RST    8'h00
`define PMP_WORD_MAX   12
`define PMP_OQ_DEPTH   16
`define PMP_LVL_MAX    3
`endif

// >>> pmp_pkg.sv
// types for the program message parser
`default_nettype none
package pmp_pkg;
   // one byte from the bus with its end flag
   typedef struct packed {
      logic [7:0] data;
      logic       eoi;
   } pmp_byte_t;
   // classification of a finished word
   typedef enum logic [4:0] {
      PMP_W_NONE = 5'b00001,
      PMP_W_PATH = 5'b00010,
      PMP_W_LEAF = 5'b00100,
      PMP_W_COMN = 5'b01000,
      PMP_W_BAD  = 5'b10000
   } pmp_word_t;
   // parser state
   typedef enum logic [2:0] {
      PMP_S_WORD = 3'b001,
      PMP_S_PARM = 3'b010,
      PMP_S_SKIP = 3'b100
   } pmp_state_t;
endpackage : pmp_pkg
`default_nettype wire

// >>> pmp_parser.sv
// program message parser: path pointer, execution, output queue, common commands
`include "pmp_defs.svh"
`default_nettype none
module pmp_parser
   import pmp_pkg::*;
(
   // clock and reset
   input  wire logic       core_clk_i,
   input  wire logic       rst_i,
   // listener byte stream
   input  wire pmp_byte_t  rx_byte_i,
   input  wire logic       rx_valid_i,
   // talker byte stream
   input  wire logic       talk_addr_i,
   input  wire logic       tx_ready_i,
   output pmp_byte_t       tx_byte_o,
   output logic            tx_valid_o,
   // word lookup from the command table
   output logic [7:0]      word_char_o [`PMP_WORD_MAX],
   output logic [3:0]      word_len_o,
   output logic [1:0]      word_lvl_o,
   input  wire pmp_word_t  word_kind_i,
   input  wire logic       word_root_opt_i,
   // execution of a device command
   output logic            exec_o,
   output logic            exec_query_o,
   input  wire logic       dev_busy_i,
   input  wire logic [7:0] dev_resp_i,
   // status
   output logic [7:0]      esr_o,
   output logic            command_error_flag_o,
   output logic            err_queue_clear_o,
   output logic            program_message_end_marker_o
);
   // ==========================================
   // state
   pmp_state_t st_q, st_d;
   logic [7:0] wc_q [`PMP_WORD_MAX];
   logic [7:0] wc_d [`PMP_WORD_MAX];
   logic [3:0] wl_q, wl_d;
   logic [1:0] lvl_q, lvl_d;
   logic       semi_q, semi_d;    // last separator was a semicolon
   logic       star_q, star_d;
   logic       qry_q, qry_d;
   logic       cut_q, cut_d;      // error cut-off active in this message
   logic [7:0] esr_q, esr_d;
   logic       opc_pend_q, opc_pend_d;
   logic       opcq_pend_q, opcq_pend_d;
   logic [7:0] oq_q [`PMP_OQ_DEPTH];
   logic [7:0] oq_d [`PMP_OQ_DEPTH];
   logic [4:0] oq_n_q, oq_n_d;
   logic [3:0] rd_q, rd_d;
   logic       exec_d, exq_d, cmd_err_d, clr_d, pme_d;
   logic [7:0] c;
   logic       is_end;

   assign c      = rx_byte_i.data;
   assign is_end = rx_valid_i & ((c == `PMP_CH_LF) | rx_byte_i.eoi);

   // word buffer to the command table, which applies short forms
   genvar gi;
   generate
      for (gi = 0; gi < `PMP_WORD_MAX; gi++)
      begin : g_wc
         assign word_char_o[gi] = wc_q[gi];
      end
   endgenerate
   assign word_len_o = wl_q;          // table checks long or short form
   assign word_lvl_o = lvl_q;

   // ==========================================
   // parser next state
   always_comb
   begin
      logic       fin;
      logic       push;
      logic [7:0] pv;
      fin = 1'b0;
      push = 1'b0;
      pv = 8'h00;
      st_d = st_q;
      wc_d = wc_q;
      wl_d = wl_q;
      lvl_d = lvl_q;
      semi_d = semi_q;
      star_d = star_q;
      qry_d = qry_q;
      cut_d = cut_q;
      esr_d = esr_q;
      opc_pend_d = opc_pend_q;
      opcq_pend_d = opcq_pend_q;
      oq_d = oq_q;
      oq_n_d = oq_n_q;
      rd_d = rd_q;
      exec_d = 1'b0;
      exq_d = 1'b0;
      cmd_err_d = 1'b0;
      clr_d = 1'b0;
      pme_d = 1'b0;
      // a word closes on separator, space or end; end of message ends it too
      if (rx_valid_i)
      begin
         case (st_q)
            PMP_S_WORD:
            begin
               if (c == `PMP_CH_COLON)
               begin
                  if (wl_q == 4'h0)
                  begin
                     if (semi_q)
                        lvl_d = 2'd0;
                     // leading colon with nothing before it: no effect
                  end
                  else
                     fin = 1'b1;
                  semi_d = 1'b0;
               end
               else if ((c == `PMP_CH_SEMI) | (c == `PMP_CH_SPACE) | is_end)
                  fin = (wl_q != 4'h0) | star_q;
               else if (c == `PMP_CH_STAR)
                  star_d = 1'b1;
               else if (c == `PMP_CH_QUERY)
                  qry_d = 1'b1;
               else if (wl_q < 4'(`PMP_WORD_MAX))
               begin
                  wc_d[wl_q] = c & ~`PMP_CASE_BIT; // fold to upper
                  wl_d = wl_q + 4'h1;
               end
            end
            PMP_S_PARM:
               if (c == `PMP_CH_SEMI)
                  st_d = PMP_S_WORD;
            default:
               st_d = PMP_S_SKIP;      // discard until terminator
         endcase
      end
      // resolve a finished word, in arrival order
      if (fin & ~cut_q)
      begin
         if (star_q)
         begin
            // common command: path pointer untouched
            if (wc_q[0] == 8'h43)
            begin
               esr_d = `PMP_ESR_RST;   // clear status
               clr_d = 1'b1;
               opc_pend_d = 1'b0;
               opcq_pend_d = 1'b0;
            end
            else if ((wc_q[0] == 8'h45) & (wc_q[2] == 8'h52) & qry_q)
            begin
               push = 1'b1;           // event status read
               pv = esr_q;
               esr_d = `PMP_ESR_RST;
            end
            else if ((wc_q[0] == 8'h4F) & qry_q)
               opcq_pend_d = 1'b1;
            else if (wc_q[0] == 8'h4F)
               opc_pend_d = 1'b1;
            else
            begin
               exec_d = 1'b1;
               exq_d = qry_q;
            end
         end
         else
         begin
            case (word_kind_i)
               PMP_W_PATH:
                  if (lvl_q < 2'(`PMP_LVL_MAX))
                     lvl_d = lvl_q + 2'd1; // only downward
               PMP_W_LEAF:
               begin
                  exec_d = 1'b1;      // level kept for next bare word
                  exq_d = qry_q;
               end
               default:
               begin
                  if (word_root_opt_i & (lvl_q == 2'd0))
                  begin
                     // optional root omitted: word stands one level down
                     // a following colon marks a path, anything else a command
                     if (c == `PMP_CH_COLON)
                        lvl_d = 2'd2;
                     else
                     begin
                        lvl_d = 2'd1;
                        exec_d = 1'b1;
                        exq_d = qry_q;
                     end
                  end
                  else
                  begin
                     cmd_err_d = 1'b1;
                     esr_d[`PMP_ESR_CMD_ERR] = 1'b1;
                     cut_d = 1'b1;
                     st_d = PMP_S_SKIP;
                  end
               end
            endcase
         end
         wl_d = 4'h0;
         star_d = 1'b0;
         qry_d = 1'b0;
         if ((c != `PMP_CH_SEMI) & ~is_end & (c != `PMP_CH_COLON) & ~cmd_err_d)
            st_d = PMP_S_PARM;
      end
      else if (fin)
         st_d = PMP_S_SKIP;
      if (rx_valid_i & (c == `PMP_CH_SEMI))
         semi_d = 1'b1;               // split at semicolon
      // pending completions wait for the device to go idle; clear status drops them
      if (opc_pend_q & ~dev_busy_i & ~clr_d)
      begin
         esr_d[`PMP_ESR_OPC] = 1'b1;
         opc_pend_d = 1'b0;
      end
      if (opcq_pend_q & ~dev_busy_i & ~push & ~clr_d)
      begin
         push = 1'b1;
         pv = `PMP_CH_ONE;
         opcq_pend_d = 1'b0;
      end
      if (exq_d & ~push)
      begin
         push = 1'b1;
         pv = dev_resp_i;
      end
      // queue responses, separator before all but the first
      if (push && oq_n_q < 5'(`PMP_OQ_DEPTH - 2)) // count stays below 16 for rd_q
      begin
         if (oq_n_q != 5'd0)
         begin
            oq_d[oq_n_q[3:0]] = `PMP_CH_SEP;
            oq_d[4'(oq_n_q + 5'd1)] = pv;
            oq_n_d = oq_n_q + 5'd2;
         end
         else
         begin
            oq_d[0] = pv;
            oq_n_d = 5'd1;
         end
      end
      // talker drain
      if (tx_valid_o & tx_ready_i)
      begin
         if (rd_q == 4'(oq_n_q))
         begin
            rd_d = 4'h0;
            oq_n_d = 5'd0;
         end
         else
            rd_d = rd_q + 4'h1;
      end
      // end of message: root again, cut-off lifted
      if (is_end)
      begin
         pme_d = 1'b1;
         lvl_d = 2'd0;
         semi_d = 1'b0;
         cut_d = 1'b0;
         st_d = PMP_S_WORD;
         wl_d = 4'h0;
         star_d = 1'b0;
         qry_d = 1'b0;
      end
   end

   // ==========================================
   // registers
   always_ff @(posedge core_clk_i or posedge rst_i)
   begin
      if (rst_i)
      begin
         st_q <= PMP_S_WORD;
         for (int i = 0; i < `PMP_WORD_MAX; i++)
            wc_q[i] <= 8'h00;
         for (int i = 0; i < `PMP_OQ_DEPTH; i++)
            oq_q[i] <= 8'h00;
         wl_q <= 4'h0;
         lvl_q <= 2'd0;
         semi_q <= 1'b0;
         star_q <= 1'b0;
         qry_q <= 1'b0;
         cut_q <= 1'b0;
         esr_q <= `PMP_ESR_RST;
         opc_pend_q <= 1'b0;
         opcq_pend_q <= 1'b0;
         oq_n_q <= 5'd0;
         rd_q <= 4'h0;
         exec_o <= 1'b0;
         exec_query_o <= 1'b0;
         command_error_flag_o <= 1'b0;
         err_queue_clear_o <= 1'b0;
         program_message_end_marker_o <= 1'b0;
      end
      else
      begin
         st_q <= st_d;
         wc_q <= wc_d;
         oq_q <= oq_d;
         wl_q <= wl_d;
         lvl_q <= lvl_d;
         semi_q <= semi_d;
         star_q <= star_d;
         qry_q <= qry_d;
         cut_q <= cut_d;
         esr_q <= esr_d;
         opc_pend_q <= opc_pend_d;
         opcq_pend_q <= opcq_pend_d;
         oq_n_q <= oq_n_d;
         rd_q <= rd_d;
         exec_o <= exec_d;
         exec_query_o <= exq_d;
         command_error_flag_o <= cmd_err_d;
         err_queue_clear_o <= clr_d;
         program_message_end_marker_o <= pme_d;
      end
   end

   // ==========================================
   // talker output: queue bytes then line feed with eoi
   always_comb
   begin
      tx_valid_o = talk_addr_i & (oq_n_q != 5'd0);
      tx_byte_o.data = (rd_q == 4'(oq_n_q)) ? `PMP_CH_LF : oq_q[rd_q];
      tx_byte_o.eoi = (rd_q == 4'(oq_n_q));
   end
   assign esr_o = esr_q;
endmodule : pmp_parser
`default_nettype wire

// >>> pmp_parser_assertions.sv
// port relation checks for the program message parser
`include "pmp_defs.svh"
`default_nettype none
// ==========================================
// checker bound to the parser
module pmp_parser_chk
   import pmp_pkg::*;
(
   // clock and reset
   input  wire logic       core_clk_i,
   input  wire logic       rst_i,
   // byte streams
   input  wire pmp_byte_t  rx_byte_i,
   input  wire logic       rx_valid_i,
   input  wire logic       talk_addr_i,
   input  wire logic       tx_ready_i,
   input  wire pmp_byte_t  tx_byte_o,
   input  wire logic       tx_valid_o,
   // execution and status
   input  wire logic       exec_o,
   input  wire logic       exec_query_o,
   input  wire logic [7:0] esr_o,
   input  wire logic       command_error_flag_o,
   input  wire logic       err_queue_clear_o,
   input  wire logic       program_message_end_marker_o
);
   default clocking @(posedge core_clk_i);
   endclocking
   default disable iff (rst_i);

   a_err_sets_bit: assert property (
      command_error_flag_o |-> esr_o[`PMP_ESR_CMD_ERR])
      else $error("error pulse without event bit");
   a_err_no_exec: assert property (command_error_flag_o |-> !exec_o)
      else $error("command executed with error");
   a_query_exec: assert property (exec_query_o |-> exec_o)
      else $error("query pulse alone");
   a_exec_one_cycle: assert property (exec_o |=> !exec_o)
      else $error("execute pulse too long");
   a_tx_talk_only: assert property (tx_valid_o |-> talk_addr_i)
      else $error("data offered while not talker");
   a_tx_byte_holds: assert property (tx_valid_o && !tx_ready_i ##1 talk_addr_i
      |-> tx_valid_o && $stable(tx_byte_o))
      else $error("offered byte changed before taken");
   a_eoi_on_lf: assert property (
      tx_valid_o && tx_byte_o.eoi |-> tx_byte_o.data == `PMP_CH_LF)
      else $error("end flag on other byte");
   a_term_ends_msg: assert property (rx_valid_i && (rx_byte_i.data == `PMP_CH_LF
      || rx_byte_i.eoi) |=> program_message_end_marker_o)
      else $error("terminator without end pulse");
   a_cls_zeroes: assert property (err_queue_clear_o |-> esr_o == `PMP_ESR_RST)
      else $error("clear status left events");
endmodule : pmp_parser_chk

bind pmp_parser pmp_parser_chk u_chk (.core_clk_i, .rst_i, .rx_byte_i, .rx_valid_i,
   .talk_addr_i, .tx_ready_i, .tx_byte_o, .tx_valid_o, .exec_o, .exec_query_o, .esr_o,
   .command_error_flag_o, .err_queue_clear_o, .program_message_end_marker_o);
`default_nettype wire

// >>> pmp_host_model.sv
// controlling computer model: sends program messages, reads responses
`default_nettype none
// ==========================================
// bus controller
module pmp_host_model
   import pmp_pkg::*;
(
   // clock
   input  wire logic      core_clk_i,
   // listener stream into the parser
   output pmp_byte_t      rx_byte_o,
   output logic           rx_valid_o,
   // talker stream out of the parser
   output logic           talk_addr_o,
   output logic           tx_ready_o,
   input  wire pmp_byte_t tx_byte_i,
   input  wire logic      tx_valid_i
);
   timeunit 1ns;
   timeprecision 1ns;
   logic      slow;   // stall every other cycle
   logic      hung;
   pmp_byte_t got [$];

   initial
   begin
      rx_byte_o = '0;
      rx_valid_o = 1'b0;
      talk_addr_o = 1'b0;
      tx_ready_o = 1'b0;
      slow = 1'b0;
      hung = 1'b0;
   end

   // one byte a cycle; end flag only on the last if asked
   task automatic send(input string s, input bit eoi_last);
      for (int i = 0; i < s.len(); i++)
      begin
         @(negedge core_clk_i);
         rx_valid_o = 1'b1;
         rx_byte_o.data = s[i];
         rx_byte_o.eoi = eoi_last && (i == s.len() - 1);
      end
      @(negedge core_clk_i);
      rx_valid_o = 1'b0;
      rx_byte_o.data = ~rx_byte_o.data;   // released: no stale value
   endtask : send

   // talk only after the query went out, and read to the end flag
   task automatic read();
      got.delete();
      hung = 1'b1;
      @(negedge core_clk_i);
      talk_addr_o = 1'b1;
      repeat (200)
      begin
         tx_ready_o = slow ? ~tx_ready_o : 1'b1;
         @(posedge core_clk_i);
         if (tx_valid_i && tx_ready_o)
            got.push_back(tx_byte_i);
         @(negedge core_clk_i);
         if (got.size() > 0 && got[got.size() - 1].eoi)
         begin
            hung = 1'b0;
            break;
         end
      end
      talk_addr_o = 1'b0;
      tx_ready_o = 1'b0;
   endtask : read
endmodule : pmp_host_model
`default_nettype wire

// >>> tb.sv
// testbench for the program message parser
`include "pmp_defs.svh"
`default_nettype none
// ==========================================
// top
module tb
   import pmp_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ns;
   logic       core_clk_i, rst_i, rx_valid, talk, ready, tx_valid, busy;
   logic       exec, exec_q, err, clr, pend, root_opt;
   pmp_byte_t  rx_byte, tx_byte;
   logic [7:0] wc [`PMP_WORD_MAX];
   logic [7:0] resp, esr;
   logic [3:0] wlen;
   logic [1:0] wlvl;
   pmp_word_t  kind;
   int         miscompares, num_checks, n_exec, n_q, n_err, n_clr, n_end;

   initial
   begin
      core_clk_i = 1'b0;
      forever #25 core_clk_i = ~core_clk_i;
   end

   pmp_parser dut (.core_clk_i(core_clk_i), .rst_i(rst_i), .rx_byte_i(rx_byte),
      .rx_valid_i(rx_valid), .talk_addr_i(talk), .tx_ready_i(ready), .tx_byte_o(tx_byte),
      .tx_valid_o(tx_valid), .word_char_o(wc), .word_len_o(wlen), .word_lvl_o(wlvl),
      .word_kind_i(kind), .word_root_opt_i(root_opt), .exec_o(exec), .exec_query_o(exec_q),
      .dev_busy_i(busy), .dev_resp_i(resp), .esr_o(esr), .command_error_flag_o(err),
      .err_queue_clear_o(clr), .program_message_end_marker_o(pend));
   pmp_host_model host (.core_clk_i(core_clk_i), .rx_byte_o(rx_byte), .rx_valid_o(rx_valid),
      .talk_addr_o(talk), .tx_ready_o(ready), .tx_byte_i(tx_byte), .tx_valid_i(tx_valid));

   // tiny command tree: S(path) > O(path), P(leaf) ; O > E(leaf)
   // M is a command under an optional root, usable at the top
   always_comb
   begin
      kind = PMP_W_BAD;
      root_opt = (wlvl == 2'h0) && (wc[0] == 8'h4D);
      if (wlen == 4'h0) kind = PMP_W_NONE;
      else if (wc[0] == `PMP_CH_STAR) kind = PMP_W_COMN;
      else if (wlvl == 2'h0 && wc[0] == 8'h53) kind = PMP_W_PATH;
      else if (wlvl == 2'h1 && wc[0] == 8'h4F) kind = PMP_W_PATH;
      else if (wlvl == 2'h1 && wc[0] == 8'h50) kind = PMP_W_LEAF;
      else if (wlvl == 2'h2 && wc[0] == 8'h45) kind = PMP_W_LEAF;
   end

   // pulse counters, cleared by say before each message
   always @(posedge core_clk_i)
   begin
      n_exec += int'(exec);
      n_q += int'(exec_q);
      n_err += int'(err);
      n_clr += int'(clr);
      n_end += int'(pend);
   end

   task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string what);
      num_checks++;
      if (got !== exp)
      begin
         miscompares++;
         $display("CHECK FAILED at %0t: %s got %h exp %h", $time, what, got, exp);
      end
   endtask : chk

   task automatic zero();
      {n_exec, n_q, n_err, n_clr, n_end} = '0;
   endtask : zero

   // pulses land one cycle after the terminator
   task automatic say(input string s, input bit eoi_last);
      zero();
      host.send(s, eoi_last);
      repeat (3) @(negedge core_clk_i);
   endtask : say

   // whole answer: given bytes, then line feed carrying the end flag
   task automatic answer(input logic [7:0] e [$]);
      host.read();
      if (host.hung)
      begin
         miscompares++;
         wrap_up();
      end
      chk(host.got.size(), e.size() + 1, "answer length");
      foreach (e[i]) chk(host.got[i].data, e[i], "answer byte");
      chk(host.got[e.size()].data, `PMP_CH_LF, "answer end byte");
      chk(host.got[e.size()].eoi, 1, "answer end flag");
   endtask : answer

   task automatic t_path();
      say("stat:oper:enab 5;enab?\n", 1'b0);
      chk(n_exec, 2, "path executes");
      chk(n_q, 1, "path queries");
      chk(n_end, 1, "path end");
      chk(tx_valid, 0, "held until talker");
      host.slow = 1'b1;
      answer('{8'h35});
      host.slow = 1'b0;
      $display("test path done");
   endtask : t_path

   task automatic t_multi();
      say("stat:oper:enab?;:stat:oper:enab?\n", 1'b0);
      chk(n_exec, 2, "root reset executes");
      chk(n_err, 0, "no error");
      answer('{8'h35, `PMP_CH_SEMI, 8'h35});
      $display("test multi done");
   endtask : t_multi

   task automatic t_opt();
      say(":stat:pres\n", 1'b1);
      chk(n_exec, 1, "leading colon executes");
      chk(n_end, 1, "line feed with end flag");
      say("stat:oper:enab 5;*CLS;enab?\n", 1'b0);
      chk(n_clr, 1, "common mid path");
      chk(n_exec, 2, "level kept past common");
      chk(n_err, 0, "no error mid path");
      answer('{8'h35});
      say("meas?\n", 1'b0);
      chk(n_exec, 1, "optional root executes");
      chk(n_err, 0, "optional root no error");
      answer('{8'h35});
      $display("test optional done");
   endtask : t_opt

   task automatic t_err();
      say("stat:pres;:oper:enab;stat:pres\n", 1'b0);
      chk(n_exec, 1, "only before error");
      chk(n_err, 1, "one error");
      chk(esr[`PMP_ESR_CMD_ERR], 1, "error event");
      say("*ESR?\n", 1'b0);
      answer('{8'h20});
      chk(esr, 0, "event read clears");
      $display("test error done");
   endtask : t_err

   task automatic t_opc();
      busy = 1'b1;
      say("*OPC\n", 1'b0);
      chk(esr[`PMP_ESR_OPC], 0, "busy holds opc");
      busy = 1'b0;
      repeat (3) @(negedge core_clk_i);
      chk(esr[`PMP_ESR_OPC], 1, "opc after work");
      say("*OPC?\n", 1'b0);
      answer('{`PMP_CH_ONE});
      $display("test opc done");
   endtask : t_opc

   task automatic t_cls();
      say("bogus\n", 1'b0);
      say("*CLS\n", 1'b0);
      chk(n_clr, 1, "clear pulse");
      chk(esr, 0, "events zero");
      say("stat:pres", 1'b1);
      chk(n_exec, 1, "end flag alone ends");
      chk(n_end, 1, "end flag pulse");
      $display("test clear done");
   endtask : t_cls

   task automatic wrap_up();
      $display("checks %0d mismatches %0d", num_checks, miscompares);
      if (miscompares == 0 && num_checks > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask : wrap_up

   // main sequence
   initial
   begin
      rst_i = 1'b1;
      busy = 1'b0;
      resp = 8'h35;
      miscompares = 0;
      num_checks = 0;
      repeat (16) @(negedge core_clk_i);
      rst_i = 1'b0;
      t_path();
      t_multi();
      t_opt();
      t_err();
      t_opc();
      t_cls();
      wrap_up();
   end

   // hang guard
   initial
   begin
      repeat (100000) @(posedge core_clk_i);
      miscompares++;
      wrap_up();
   end
endmodule : tb
`default_nettype wire
